// File: pkg/scs_pkg.sv
// Package for the successive approximation conversion sequencer.
// Assumes a single 25 MHz system clock; converter clock is an enable pulse.
package scs_pkg;

  // ==========================================================
  // Converter geometry
  localparam int unsigned RES_BITS = 10;
  localparam int unsigned CHANNELS = 6;
  localparam logic [2:0] CHANNEL_LAST = 3'h5;

  // ==========================================================
  // Conversion timing, in converter clock cycles
  // Sample point is this count plus one half cycle.
  localparam logic [4:0] SAMPLE_CYC_NORMAL = 5'h01;
  localparam logic [4:0] SAMPLE_CYC_FIRST = 5'h0d;
  // Successive approximation decisions after the first trial
  localparam logic [4:0] DECIDE_SPAN = 5'h0a;
  // Result written this many cycles after the sample cycle count
  localparam logic [4:0] WRITE_AFTER_SAMPLE = 5'h0b;

  // ==========================================================
  // Reset values
  localparam logic [6:0] PRESC_RESET = 7'h00;
  localparam logic [4:0] CYC_RESET = 5'h00;
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [9:0] CODE_MSB = 10'h200;
  localparam logic [2:0] CHAN_RESET = 3'h0;

  typedef enum logic [1:0] {
    SCS_IDLE  = 2'b00,
    SCS_CONV  = 2'b01,
    SCS_EXTRA = 2'b10
  } scs_state_e;

  // Software-facing control bits of the converter control and status register
  typedef struct packed {
    logic converter_enable;
    logic start_set;
    logic free_run;
    logic int_enable;
    logic flag_clear;
    logic int_ack;
    logic [2:0] prescale_sel;
    logic [2:0] channel_sel;
  } scs_ctrl_s;

  typedef struct packed {
    scs_state_e state;
    logic [6:0] presc;
    logic [4:0] cyc;
    logic first;
    logic start_bit;
    logic flag;
    logic irq;
    logic hold_pulse;
    logic result_valid;
    logic [9:0] code;
    logic [9:0] result;
    logic [2:0] mux_sel;
    logic cmp_meta;
    logic cmp_sync;
  } scs_state_s;

endpackage : scs_pkg

// File: src/scs_sequencer.sv
// Conversion sequencer: prescaler, timing, SAR register, flag and interrupt.
// Assumes a synchronous control source and an asynchronous comparator pin.
//
// Functional notes
// R1 - Prescaler runs while converter enabled, held reset while enable low.
// R2 - Conversion begins on next converter clock rise after start bit set.
// R3 - Normal conversion samples 1.5 converter cycles after start.
// R4 - Normal conversion writes result 13 converter cycles after start.
// R5 - Single mode adds one cycle after write, 14 cycles total.
// R6 - Start bit set during that extra cycle starts conversion immediately.
// R7 - Free-running mode restarts right after each write, 13 cycles total.
// R8 - First conversion samples at 13.5, writes at 25; totals 25 or 26.
// R9 - One of six input channels routed to converter by the multiplexer.
// R10 - Result is a 10-bit successive approximation value.
// R11 - Interrupt request can be raised when a conversion completes.
// R12 - Free-running and single software-triggered modes selectable.
// R13 - Start bit reads one during conversion, cleared at single-mode write.
// R14 - Complete flag set on write, cleared by service or software, gates irq.
`timescale 1ns/1ps
`default_nettype none

module scs_sequencer (
  input wire logic clock,
  input wire logic rst,
  input wire scs_pkg::scs_ctrl_s ctrl,
  input wire logic comparator_in,
  output logic conversion_start_bit,
  output logic complete_flag,
  output logic irq,
  output logic hold_pulse,
  output logic result_valid,
  output logic [2:0] mux_select,
  output logic [9:0] dac_code,
  output logic [9:0] result
);

  scs_pkg::scs_state_s st_reg;
  scs_pkg::scs_state_s st_next;

  // ==========================================================
  // Prescaler decode
  logic [2:0] sel_eff;
  logic [6:0] div_last;
  logic [6:0] half_last;
  logic rise;
  logic fall;
  logic [4:0] sample_cyc;
  logic [4:0] bit_idx;
  logic write_now;

  always_comb begin
    // Divide by four at least: the comparator synchroniser needs three clocks per trial
    sel_eff = (ctrl.prescale_sel < 3'h2) ? 3'h2 : ctrl.prescale_sel;
    div_last = 7'((8'h01 << sel_eff) - 8'h01);
    half_last = 7'((8'h01 << (sel_eff - 3'h1)) - 8'h01);
    rise = (st_reg.presc == div_last);
    fall = (st_reg.presc == half_last);
    sample_cyc = st_reg.first ? scs_pkg::SAMPLE_CYC_FIRST : scs_pkg::SAMPLE_CYC_NORMAL; // see R8
    bit_idx = 5'(sample_cyc + scs_pkg::DECIDE_SPAN - st_reg.cyc);
    write_now = rise && (st_reg.state == scs_pkg::SCS_CONV)
      && (st_reg.cyc == 5'(sample_cyc + scs_pkg::WRITE_AFTER_SAMPLE));
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.hold_pulse = 1'b0;
    st_next.result_valid = 1'b0;
    st_next.cmp_meta = comparator_in;
    st_next.cmp_sync = st_reg.cmp_meta;

    if (!ctrl.converter_enable) begin
      // Disabling aborts any conversion and rearms the long first conversion
      st_next.presc = scs_pkg::PRESC_RESET; // see R1
      st_next.state = scs_pkg::SCS_IDLE;
      st_next.cyc = scs_pkg::CYC_RESET;
      st_next.first = 1'b1;
      st_next.start_bit = 1'b0;
      st_next.code = scs_pkg::CODE_RESET;
    end else begin
      st_next.presc = rise ? scs_pkg::PRESC_RESET : 7'(st_reg.presc + 7'h01); // see R1
      if (ctrl.start_set) begin
        st_next.start_bit = 1'b1; // see R13
      end
      if (fall && st_reg.state == scs_pkg::SCS_CONV && st_reg.cyc == sample_cyc) begin
        st_next.hold_pulse = 1'b1; // see R3 see R8
      end
      if (rise) begin
        case (st_reg.state)
          scs_pkg::SCS_IDLE, scs_pkg::SCS_EXTRA: begin
            // Start on this rise; a start set during the extra cycle lands here too
            if (st_reg.start_bit || ctrl.start_set) begin
              st_next.state = scs_pkg::SCS_CONV; // see R2 see R6
              st_next.cyc = scs_pkg::CYC_RESET;
              st_next.code = scs_pkg::CODE_RESET;
              st_next.mux_sel = (ctrl.channel_sel > scs_pkg::CHANNEL_LAST)
                ? scs_pkg::CHANNEL_LAST : ctrl.channel_sel; // see R9
            end else begin
              st_next.state = scs_pkg::SCS_IDLE;
            end
          end
          scs_pkg::SCS_CONV: begin
            st_next.cyc = 5'(st_reg.cyc + 5'h01);
            if (st_reg.cyc == sample_cyc) begin
              st_next.code = scs_pkg::CODE_MSB; // see R10
            end else if (st_reg.cyc > sample_cyc
                && st_reg.cyc <= 5'(sample_cyc + scs_pkg::DECIDE_SPAN)) begin
              // Comparator high means the input is above the trial level
              if (!st_reg.cmp_sync) begin
                st_next.code[bit_idx[3:0]] = 1'b0; // see R10
              end
              if (bit_idx != 5'h00) begin
                st_next.code[4'(bit_idx - 5'h01)] = 1'b1;
              end
            end
            if (write_now) begin
              st_next.result = st_reg.code; // see R4 see R8
              st_next.result_valid = 1'b1;
              st_next.first = 1'b0;
              if (ctrl.free_run) begin
                st_next.state = scs_pkg::SCS_CONV; // see R7 see R12
                st_next.cyc = scs_pkg::CYC_RESET;
                st_next.code = scs_pkg::CODE_RESET;
                st_next.mux_sel = (ctrl.channel_sel > scs_pkg::CHANNEL_LAST)
                  ? scs_pkg::CHANNEL_LAST : ctrl.channel_sel; // see R9
              end else begin
                st_next.state = scs_pkg::SCS_EXTRA; // see R5 see R12
                // A start set in this very cycle is kept
                st_next.start_bit = ctrl.start_set; // see R13
              end
            end
          end
          default: begin
            st_next.state = scs_pkg::SCS_IDLE;
          end
        endcase
      end
    end

    // Set wins over a clear arriving in the same cycle
    if (ctrl.flag_clear || ctrl.int_ack) begin
      st_next.flag = 1'b0; // see R14
    end
    if (write_now && ctrl.converter_enable) begin
      st_next.flag = 1'b1; // see R14
    end
    st_next.irq = st_next.flag && ctrl.int_enable; // see R11 see R14
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg.state <= scs_pkg::SCS_IDLE;
      st_reg.presc <= scs_pkg::PRESC_RESET;
      st_reg.cyc <= scs_pkg::CYC_RESET;
      st_reg.first <= 1'b1;
      st_reg.start_bit <= 1'b0;
      st_reg.flag <= 1'b0;
      st_reg.irq <= 1'b0;
      st_reg.hold_pulse <= 1'b0;
      st_reg.result_valid <= 1'b0;
      st_reg.code <= scs_pkg::CODE_RESET;
      st_reg.result <= scs_pkg::CODE_RESET;
      st_reg.mux_sel <= scs_pkg::CHAN_RESET;
      st_reg.cmp_meta <= 1'b0;
      st_reg.cmp_sync <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign conversion_start_bit = st_reg.start_bit;
  assign complete_flag = st_reg.flag;
  assign irq = st_reg.irq;
  assign hold_pulse = st_reg.hold_pulse;
  assign result_valid = st_reg.result_valid;
  assign mux_select = st_reg.mux_sel;
  assign dac_code = st_reg.code;
  assign result = st_reg.result;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seq_start_rise;
    rise && ctrl.converter_enable && st_reg.state != scs_pkg::SCS_CONV
      && (st_reg.start_bit || ctrl.start_set);
  endsequence

  sequence seq_write;
    write_now && ctrl.converter_enable;
  endsequence

  a_presc_held: assert property (!ctrl.converter_enable |=> st_reg.presc == 7'h00) // see R1
    else $error("prescaler not held while disabled");

  a_start_on_rise: assert property (seq_start_rise // see R2
      |=> st_reg.state == scs_pkg::SCS_CONV && st_reg.cyc == 5'h00)
    else $error("conversion did not start on converter rise");

  a_hold_normal: assert property (hold_pulse && !st_reg.first // see R3
      |-> st_reg.cyc == 5'h01 && $past(fall))
    else $error("normal sample point wrong");

  a_hold_first: assert property (hold_pulse && st_reg.first |-> st_reg.cyc == 5'h0d) // see R8
    else $error("first sample point wrong");

  a_write_cycle: assert property (seq_write // see R4 see R8
      |-> st_reg.cyc == (st_reg.first ? 5'h18 : 5'h0c) ##1 result_valid && complete_flag)
    else $error("result write at wrong cycle");

  a_single_extra: assert property (seq_write ##0 !ctrl.free_run // see R5
      |=> st_reg.state == scs_pkg::SCS_EXTRA)
    else $error("single mode missing extra cycle");

  a_extra_start: assert property (st_reg.state == scs_pkg::SCS_EXTRA && rise // see R6
      && (st_reg.start_bit || ctrl.start_set) && ctrl.converter_enable
      |=> st_reg.state == scs_pkg::SCS_CONV)
    else $error("start in extra cycle delayed");

  a_free_restart: assert property (seq_write ##0 ctrl.free_run // see R7
      |=> st_reg.state == scs_pkg::SCS_CONV && st_reg.cyc == 5'h00)
    else $error("free run did not restart");

  a_mux_range: assert property (mux_select <= scs_pkg::CHANNEL_LAST) // see R9
    else $error("channel out of range");

  a_start_clear: assert property (seq_write ##0 !ctrl.free_run ##0 !ctrl.start_set // see R13
      |=> !conversion_start_bit)
    else $error("start bit not cleared at write");

  a_irq_gate: assert property (irq |-> complete_flag) // see R14
    else $error("interrupt without flag");

  // ==========================================================
  // Flag, interrupt and start bit
  a_irq_follow: assert property (irq == (complete_flag && $past(ctrl.int_enable))) // see R11
    else $error("interrupt does not follow flag and enable");

  a_flag_set: assert property (seq_write |=> complete_flag) // see R14
    else $error("flag not set at write");

  a_flag_clear: assert property ((ctrl.flag_clear || ctrl.int_ack) // see R14
      && !(write_now && ctrl.converter_enable) |=> !complete_flag)
    else $error("flag not cleared");

  a_flag_hold: assert property (complete_flag && !ctrl.flag_clear && !ctrl.int_ack // see R14
      |=> complete_flag)
    else $error("flag lost without a clear");

  a_start_set: assert property (ctrl.start_set && ctrl.converter_enable // see R13
      |=> conversion_start_bit)
    else $error("start bit not set");

  a_start_refused: assert property (!ctrl.converter_enable |=> !conversion_start_bit) // see R13
    else $error("start bit set while disabled");

  a_busy_start: assert property (st_reg.state == scs_pkg::SCS_CONV // see R13
      |-> conversion_start_bit)
    else $error("start bit low during conversion");

  a_free_keep: assert property (seq_write ##0 ctrl.free_run // see R13
      |=> conversion_start_bit)
    else $error("start bit dropped in free run");

  // ==========================================================
  // Sample point, result, channel, extra cycle, disable and prescaler
  a_result_change: assert property ($changed(result) |-> result_valid) // see R4
    else $error("result changed without a write");

  a_valid_pulse: assert property (result_valid |=> !result_valid) // see R4
    else $error("result valid longer than one clock");

  a_hold_pulse: assert property (hold_pulse |=> !hold_pulse) // see R3
    else $error("hold pulse longer than one clock");

  a_first_clear: assert property (seq_write |=> !st_reg.first) // see R8
    else $error("long first conversion not cleared");

  sequence seq_msb_rise;
    rise && ctrl.converter_enable && st_reg.state == scs_pkg::SCS_CONV
      && st_reg.cyc == sample_cyc;
  endsequence

  a_msb_trial: assert property (seq_msb_rise |=> dac_code == scs_pkg::CODE_MSB) // see R10
    else $error("first trial is not the top bit");

  a_mux_steady: assert property ($changed(mux_select) |-> $past(rise)) // see R9
    else $error("channel changed off a converter rise");

  a_extra_idle: assert property (st_reg.state == scs_pkg::SCS_EXTRA && rise // see R5
      && ctrl.converter_enable && !st_reg.start_bit && !ctrl.start_set
      |=> st_reg.state == scs_pkg::SCS_IDLE)
    else $error("extra cycle did not fall idle");

  a_disable_abort: assert property (!ctrl.converter_enable // see R1
      |=> st_reg.state == scs_pkg::SCS_IDLE && st_reg.first)
    else $error("disable did not abort");

  a_presc_count: assert property (ctrl.converter_enable && !rise // see R1
      |=> st_reg.presc == 7'($past(st_reg.presc) + 7'h01))
    else $error("prescaler did not count");

endmodule : scs_sequencer

`default_nettype wire

// File: test/scs_analog_model.sv
// Far-side model: six analog levels behind the input multiplexer and the comparator.
// Assumes levels are exact codes plus half a step, so a trial at or under the level wins.
`timescale 1ns/1ps
`default_nettype none

module scs_analog_model #(
  parameter int SETTLE_NS = 5
) (
  input wire logic [2:0] mux_select,
  input wire logic [9:0] dac_code,
  input wire logic [59:0] levels,
  output var logic comparator_in
);
  // ==========================================================
  // Comparator with a settling delay
  initial comparator_in = 1'b0;
  always @(mux_select or dac_code or levels) begin
    if (mux_select <= 3'h5) begin
      comparator_in <= #(SETTLE_NS) (levels[int'(mux_select) * 10 +: 10] >= dac_code);
    end else begin
      // No such channel: answer garbage rather than a stale level
      comparator_in <= #(SETTLE_NS) ~comparator_in;
    end
  end
endmodule : scs_analog_model

`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the conversion sequencer, converter clock at clock / 4 and / 8.
// Assumes the analog model settles well inside one converter cycle.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clock;
  logic rst;
  scs_pkg::scs_ctrl_s ctrl;
  logic cmp, start_bit, flag, irq, hold, valid;
  logic [2:0] mux;
  logic [9:0] dac;
  logic [9:0] result;
  logic [59:0] levels;
  int n_errors;
  int total_checks;
  int n;
  int m;

  scs_sequencer dut (.clock(clock), .rst(rst), .ctrl(ctrl), .comparator_in(cmp),
    .conversion_start_bit(start_bit), .complete_flag(flag), .irq(irq), .hold_pulse(hold),
    .result_valid(valid), .mux_select(mux), .dac_code(dac), .result(result));
  scs_analog_model #(.SETTLE_NS(5)) far_side (.mux_select(mux), .dac_code(dac),
    .levels(levels), .comparator_in(cmp));

  // ==========================================================
  // Clock, watchdog, verdict
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Helpers
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : tick
  task automatic chk_val(input string what, input logic [9:0] exp, input logic [9:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk_val
  task automatic chk_span(input string what, input int lo, input int hi, input int seen);
    total_checks++;
    if (seen < lo || seen > hi) begin
      n_errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask : chk_span
  // Pulses must end before the next edge, so one edge always passes
  task automatic pulse(input logic [11:0] mask);
    ctrl = scs_pkg::scs_ctrl_s'(ctrl | mask);
    tick(1);
    ctrl = scs_pkg::scs_ctrl_s'(ctrl & ~mask);
  endtask : pulse
  task automatic wait_for(input logic on_valid, input int limit, output int k);
    k = 0;
    while (k < limit && (on_valid ? valid : hold) !== 1'b1) begin
      tick(1);
      k++;
    end
  endtask : wait_for

  // ==========================================================
  // Scenarios
  task automatic sc_reset();
    chk_val("status", 10'h000, {5'h00, start_bit, flag, irq, hold, valid});
    pulse(12'h400);
    chk_val("start_bit", 10'h000, {9'h000, start_bit});
  endtask : sc_reset
  task automatic sc_first_single();
    ctrl.converter_enable = 1'b1;
    ctrl.prescale_sel = 3'h2;
    tick(3);
    pulse(12'h400);
    chk_val("start_bit", 10'h001, {9'h000, start_bit});
    wait_for(1'b0, 200, n);
    chk_span("first hold", 54, 59, n);
    tick(2);
    chk_val("trial msb", 10'h200, dac);
    wait_for(1'b1, 200, n);
    chk_span("first write", 44, 44, n);
    chk_val("start_bit", 10'h000, {9'h000, start_bit});
    chk_val("flag", 10'h001, {9'h000, flag});
    chk_val("result", levels[9:0], result);
  endtask : sc_first_single
  // Each start lands in the extra cycle of the one before
  task automatic sc_chain();
    for (int ch = 0; ch < 7; ch++) begin
      int e;
      e = (ch > 5) ? 5 : ch;
      ctrl.channel_sel = 3'(ch);
      pulse(12'h400);
      wait_for(1'b0, 100, n);
      wait_for(1'b1, 100, m);
      chk_span("hold", 9, 9, n);
      chk_span("write", 46, 46, m);
      chk_span("single period", 56, 56, n + m + 1);
      chk_val("channel", 10'(e), {7'h00, mux});
      chk_val("result", levels[e * 10 +: 10], result);
    end
  endtask : sc_chain
  task automatic sc_irq();
    tick(8);
    chk_val("irq gated", 10'h000, {9'h000, irq});
    ctrl.int_enable = 1'b1;
    tick(2);
    chk_val("irq", 10'h001, {9'h000, irq});
    pulse(12'h040);
    tick(1);
    chk_val("flag irq", 10'h000, {8'h00, flag, irq});
    pulse(12'h400);
    wait_for(1'b1, 100, n);
    tick(1);
    chk_val("flag irq", 10'h003, {8'h00, flag, irq});
    pulse(12'h080);
    tick(1);
    chk_val("flag irq", 10'h000, {8'h00, flag, irq});
  endtask : sc_irq
  task automatic sc_free_run();
    ctrl.free_run = 1'b1;
    pulse(12'h400);
    wait_for(1'b1, 100, n);
    for (int i = 0; i < 2; i++) begin
      tick(1);
      wait_for(1'b1, 100, n);
      chk_span("free period", 51, 51, n);
      chk_val("start_bit", 10'h001, {9'h000, start_bit});
    end
  endtask : sc_free_run
  task automatic sc_disable();
    tick(10);
    ctrl.converter_enable = 1'b0;
    tick(2);
    chk_val("start_bit", 10'h000, {9'h000, start_bit});
    wait_for(1'b1, 120, n);
    chk_span("aborted write", 120, 120, n);
    ctrl.converter_enable = 1'b1;
    pulse(12'h400);
    wait_for(1'b0, 100, n);
    chk_span("re-enabled hold", 54, 59, n);
    wait_for(1'b1, 100, n);
    chk_span("re-enabled write", 46, 46, n);
    tick(1);
    wait_for(1'b1, 100, n);
    chk_span("free period", 51, 51, n);
  endtask : sc_disable
  // Slower converter clock: long first conversion, then a start in its extra cycle
  task automatic sc_prescale();
    ctrl.converter_enable = 1'b0;
    tick(1);
    ctrl.free_run = 1'b0;
    ctrl.prescale_sel = 3'h3;
    ctrl.converter_enable = 1'b1;
    pulse(12'h400);
    wait_for(1'b0, 200, n);
    wait_for(1'b1, 200, m);
    chk_span("slow first hold", 115, 115, n);
    chk_span("slow first write", 92, 92, m);
    pulse(12'h400);
    wait_for(1'b0, 100, n);
    wait_for(1'b1, 100, m);
    chk_span("slow hold", 19, 19, n);
    chk_span("slow write", 92, 92, m);
    chk_val("slow result", levels[59:50], result);
  endtask : sc_prescale

  // ==========================================================
  // Main sequence
  initial begin
    ctrl = scs_pkg::scs_ctrl_s'(12'h000);
    rst = 1'b1;
    n_errors = 0;
    total_checks = 0;
    levels = {10'h2aa, 10'h155, 10'h1ff, 10'h200, 10'h000, 10'h3ff};
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    sc_reset();
    sc_first_single();
    sc_chain();
    sc_irq();
    sc_free_run();
    sc_disable();
    sc_prescale();
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
